/* File: clm_pkg.sv */
package clm_pkg;

   // Register byte addresses
   localparam logic [7:0] OFS_WINDOW = 8'h00;
   localparam logic [7:0] OFS_EXPECT = 8'h04;
   localparam logic [7:0] OFS_MARGIN = 8'h08;
   localparam logic [7:0] OFS_QUAL   = 8'h0C;
   localparam logic [7:0] OFS_STATE  = 8'h10;
   localparam logic [7:0] OFS_EVENT  = 8'h14;
   localparam logic [7:0] OFS_TALLY  = 8'h18;
   localparam logic [7:0] OFS_CTRL   = 8'h1C;

   // Field layout
   localparam int DIV_W       = 5;
   localparam int EXP_W       = 16;
   localparam int MARGIN_W    = 15;
   localparam int ACC_LSB     = 16;
   localparam int QCNT_W      = 4;
   localparam int GOOD_LSB    = 4;
   localparam int TALLY_W     = 4;
   localparam int THRESH_LSB  = 8;
   localparam int MASK_BIT    = 5;
   localparam int SRST_BIT    = 0;
   localparam int GATE_BIT    = 1;
   localparam int ST_LOS_BIT  = 0;
   localparam int ST_INV_BIT  = 1;
   localparam int EV_LOS_BIT  = 0;
   localparam int EV_LMT_BIT  = 1;

   // Reset values and limits
   localparam logic [QCNT_W-1:0]  QUAL_RST  = 4'h4;
   localparam logic [TALLY_W-1:0] TALLY_MAX = 4'hF;
   localparam logic [EXP_W-1:0]   COUNT_MAX = 16'hFFFF;
   localparam logic [DIV_W-1:0]   DIV_ONE   = 5'h01;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {
      CLM_ST_LOST,
      CLM_ST_GOOD
   } clm_los_state_t;

endpackage

/* File: clm_top.sv */
`timescale 1ns/1ps
module clm_top (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        mon_clk_i,
   input  wire logic        freq_invalid_i,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             los_status_o,
   output logic             ref_invalid_o
);

   logic                                rst_meta;
   logic                                rst_n;
   // Bus holding registers
   logic                                aw_held;
   logic                                w_held;
   logic [7:0]                          aw_addr;
   logic [31:0]                         w_data;
   logic [3:0]                          w_strb;
   logic                                do_write;
   logic [31:0]                         wr_old;
   logic [31:0]                         wr_val;
   logic                                wr_hit;
   logic [31:0]                         next_rdata;
   logic                                rd_hit;
   // Software registers
   logic [clm_pkg::DIV_W-1:0]           div_ratio;
   logic [clm_pkg::EXP_W-1:0]           expected;
   logic [clm_pkg::MARGIN_W-1:0]        acc_margin;
   logic [clm_pkg::MARGIN_W-1:0]        rej_margin;
   logic [clm_pkg::QCNT_W-1:0]          good_times;
   logic [clm_pkg::QCNT_W-1:0]          fail_times;
   logic [clm_pkg::TALLY_W-1:0]         thresh;
   logic                                fail_mask;
   logic                                soft_reset;
   logic                                clock_gate;
   // Monitor state
   clm_pkg::clm_los_state_t             los_state;
   logic [clm_pkg::QCNT_W-1:0]          good_cnt;
   logic [clm_pkg::QCNT_W-1:0]          fail_cnt;
   logic [clm_pkg::TALLY_W-1:0]         tally;
   logic                                evt_los;
   logic                                evt_lmt;
   logic                                los_now;
   logic                                lmt_now;
   logic [clm_pkg::EXP_W:0]             diff;
   logic                                win_acc;
   logic                                win_rej;

   clm_win_if win ();

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Held cleared while gated, in soft reset or with a zero expected count
   assign win.enable    = ~soft_reset & ~clock_gate & (expected != '0);
   assign win.div_ratio = div_ratio;

   clm_window_meas u_meas (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n),
      .mon_clk_i (mon_clk_i),
      .win       (win)
   );

   // ---------------- AXI4-Lite write path
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= clm_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? clm_pkg::RESP_OKAY : clm_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign do_write = aw_held & w_held & ~s_axi_bvalid;

   always_comb begin
      wr_hit = 1'b1;
      wr_old = '0;
      case (aw_addr)
         clm_pkg::OFS_WINDOW: wr_old = {27'h0, div_ratio};
         clm_pkg::OFS_EXPECT: wr_old = {16'h0, expected};
         clm_pkg::OFS_MARGIN: wr_old = {1'b0, acc_margin, 1'b0, rej_margin};
         clm_pkg::OFS_QUAL:   wr_old = {24'h0, good_times, fail_times};
         clm_pkg::OFS_STATE:  wr_old = '0;
         clm_pkg::OFS_EVENT:  wr_old = '0;
         clm_pkg::OFS_TALLY:  wr_old = {28'h0, tally};
         clm_pkg::OFS_CTRL:   wr_old = {20'h0, thresh, 2'h0, fail_mask, 3'h0, clock_gate, soft_reset};
         default:             wr_hit = 1'b0;
      endcase
   end

   // Byte lanes not strobed keep their old value
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wr_val[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : wr_old[i*8 +: 8];
      end
   end

   // ---------------- Configuration registers
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         div_ratio  <= '0;
         expected   <= '0;
         acc_margin <= '0;
         rej_margin <= '0;
         good_times <= clm_pkg::QUAL_RST;
         fail_times <= clm_pkg::QUAL_RST;
         thresh     <= '0;
         fail_mask  <= 1'b0;
         soft_reset <= 1'b0;
         clock_gate <= 1'b0;
      end else if (do_write) begin
         case (aw_addr)
            clm_pkg::OFS_WINDOW: div_ratio <= wr_val[clm_pkg::DIV_W-1:0];
            clm_pkg::OFS_EXPECT: expected <= wr_val[clm_pkg::EXP_W-1:0];
            clm_pkg::OFS_MARGIN: begin
               acc_margin <= wr_val[clm_pkg::ACC_LSB +: clm_pkg::MARGIN_W];
               rej_margin <= wr_val[clm_pkg::MARGIN_W-1:0];
            end
            clm_pkg::OFS_QUAL: begin
               good_times <= wr_val[clm_pkg::GOOD_LSB +: clm_pkg::QCNT_W];
               fail_times <= wr_val[clm_pkg::QCNT_W-1:0];
            end
            clm_pkg::OFS_CTRL: begin
               thresh     <= wr_val[clm_pkg::THRESH_LSB +: clm_pkg::TALLY_W];
               fail_mask  <= wr_val[clm_pkg::MASK_BIT];
               clock_gate <= wr_val[clm_pkg::GATE_BIT];
               soft_reset <= wr_val[clm_pkg::SRST_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------- Window classification
   always_comb begin
      if (win.win_count >= expected) begin
         diff = {1'b0, win.win_count} - {1'b0, expected};
      end else begin
         diff = {1'b0, expected} - {1'b0, win.win_count};
      end
   end

   assign win_acc = win.win_done && (diff <= {2'h0, acc_margin});
   assign win_rej = win.win_done && (diff > {2'h0, rej_margin});

   // Qualify / disqualify tallies
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         los_state <= clm_pkg::CLM_ST_LOST;
         good_cnt  <= '0;
         fail_cnt  <= '0;
      end else if (soft_reset) begin
         los_state <= clm_pkg::CLM_ST_LOST;
         good_cnt  <= '0;
         fail_cnt  <= '0;
      end else if (win_rej) begin
         good_cnt <= '0;
         case (los_state)
            clm_pkg::CLM_ST_GOOD: begin
               if (fail_cnt + 4'h1 >= fail_times) begin
                  los_state <= clm_pkg::CLM_ST_LOST;
                  fail_cnt  <= '0;
               end else begin
                  fail_cnt <= fail_cnt + 4'h1;
               end
            end
            default: fail_cnt <= '0;
         endcase
      end else if (win_acc) begin
         case (los_state)
            clm_pkg::CLM_ST_LOST: begin
               if (good_cnt + 4'h1 >= good_times) begin
                  los_state <= clm_pkg::CLM_ST_GOOD;
                  good_cnt  <= '0;
                  fail_cnt  <= '0;
               end else begin
                  good_cnt <= good_cnt + 4'h1;
               end
            end
            default: good_cnt <= '0;
         endcase
      end
   end

   assign los_now = (los_state == clm_pkg::CLM_ST_LOST) | (expected == '0);
   assign lmt_now = (tally > thresh);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         los_status_o <= 1'b1;
      end else begin
         los_status_o <= los_now;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ref_invalid_o <= 1'b1;
      end else begin
         ref_invalid_o <= (los_now & ~fail_mask) | freq_invalid_i;
      end
   end

   // Failure tally; a software load beats a same-cycle increment
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tally <= '0;
      end else if (do_write && aw_addr == clm_pkg::OFS_TALLY) begin
         if (!clock_gate && !soft_reset) begin
            tally <= wr_val[clm_pkg::TALLY_W-1:0];
         end
      end else if (los_now && !los_status_o && tally != clm_pkg::TALLY_MAX) begin
         tally <= tally + 4'h1;
      end
   end

   // Sticky events; a live condition beats the clear
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         // loss event set out of reset
         evt_los <= 1'b1;
         evt_lmt <= 1'b0;
      end else begin
         evt_los <= los_now | (evt_los & ~(do_write && aw_addr == clm_pkg::OFS_EVENT && wr_val[clm_pkg::EV_LOS_BIT]));
         evt_lmt <= lmt_now | (evt_lmt & ~(do_write && aw_addr == clm_pkg::OFS_EVENT && wr_val[clm_pkg::EV_LMT_BIT]));
      end
   end

   // ---------------- AXI4-Lite read path
   always_comb begin
      rd_hit     = 1'b1;
      next_rdata = '0;
      case (s_axi_araddr)
         clm_pkg::OFS_WINDOW: next_rdata = {27'h0, div_ratio};
         clm_pkg::OFS_EXPECT: next_rdata = {16'h0, expected};
         clm_pkg::OFS_MARGIN: next_rdata = {1'b0, acc_margin, 1'b0, rej_margin};
         clm_pkg::OFS_QUAL:   next_rdata = {24'h0, good_times, fail_times};
         clm_pkg::OFS_STATE:  next_rdata = {30'h0, ref_invalid_o, los_status_o};
         clm_pkg::OFS_EVENT:  next_rdata = {30'h0, evt_lmt, evt_los};
         clm_pkg::OFS_TALLY:  next_rdata = {28'h0, tally};
         clm_pkg::OFS_CTRL:   next_rdata = {20'h0, thresh, 2'h0, fail_mask, 3'h0, clock_gate, soft_reset};
         default:             rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= clm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= rd_hit ? clm_pkg::RESP_OKAY : clm_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule

/* File: clm_top_chk.sv */
`timescale 1ns/1ps
module clm_top_chk (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        freq_invalid_i,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        los_status_o,
   input  wire logic        ref_invalid_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   wire logic wr_both;
   assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

   a_reset_status: assert property ($rose(rstn_i) |-> los_status_o && ref_invalid_o)
      else $error("status not set after reset");
   a_invalid_freq: assert property (freq_invalid_i |=> ref_invalid_o)
      else $error("frequency failure not shown as invalid");
   a_valid_when_clear: assert property ((!los_status_o && !freq_invalid_i) [*4] |-> !ref_invalid_o)
      else $error("invalid without a cause");
   a_expect_zero_los: assert property (wr_both && s_axi_awaddr == clm_pkg::OFS_EXPECT &&
      s_axi_wstrb[1:0] == 2'h3 && s_axi_wdata[15:0] == 16'h0000 |-> ##[1:12] los_status_o)
      else $error("zero expected count did not raise loss");
   a_write_answer: assert property (wr_both |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read response dropped");
   a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > clm_pkg::OFS_CTRL |=>
      s_axi_rresp == clm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");

   c_qualified: cover property ($fell(los_status_o));
   c_lost: cover property ($rose(los_status_o));
   c_valid: cover property ($fell(ref_invalid_o));
endmodule

/* File: clm_top_test.sv */
`timescale 1ns/1ps
module clm_top_test;
   logic        clk_i = 1'b0, rstn_i = 1'b0, mon_clk = 1'b0, freq_inv = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, los_status_o, ref_invalid_o;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          mon_half = 10, mon_cnt = 0, n_errors = 0, num_checks = 0;

   always #2.5 clk_i = ~clk_i;

   // Monitored clock made in clk_i cycles so the window count is exact
   always @(posedge clk_i) begin
      if (mon_cnt + 1 >= mon_half) begin
         mon_cnt <= 0;
         mon_clk <= ~mon_clk;
      end else begin
         mon_cnt <= mon_cnt + 1;
      end
   end

   clm_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .mon_clk_i(mon_clk), .freq_invalid_i(freq_inv),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .los_status_o(los_status_o), .ref_invalid_o(ref_invalid_o));

   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Both channels offered together; each released at its own handshake
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw_d, w_d;
      aw_d = 0;
      w_d = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(posedge clk_i);
         if (!aw_d && awready === 1'b1) begin
            aw_d = 1;
            awvalid <= 1'b0;
         end
         if (!w_d && wready === 1'b1) begin
            w_d = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk_i); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk($sformatf("bresp %h", a), {30'h0, bresp}, {30'h0, er});
      @(posedge clk_i);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_i); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk($sformatf("rdata %h", a), rdata, ed);
      chk($sformatf("rresp %h", a), {30'h0, rresp}, {30'h0, er});
      @(posedge clk_i);
   endtask

   // Bounded wait on an output level; sel picks ref_invalid over los_status
   task automatic wait_out(input bit sel, input logic v);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (((sel ? ref_invalid_o : los_status_o) !== v) && n < 3000);
      chk(sel ? "ref_invalid" : "los_status", {31'h0, sel ? ref_invalid_o : los_status_o}, {31'h0, v});
   endtask

   task automatic t_reset_values;
      rd_chk(clm_pkg::OFS_QUAL, 32'h0000_0044, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_STATE, 32'h0000_0003, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_EVENT, 32'h0000_0001, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_TALLY, 32'h0000_0000, clm_pkg::RESP_OKAY);
      rd_chk(8'h20, 32'h0000_0000, clm_pkg::RESP_SLVERR);
      wr(8'h24, 32'h0000_00FF, clm_pkg::RESP_SLVERR);
   endtask

   // Window of 20 periods against 22 +/- 2: only the exact count sits on the accept edge
   task automatic t_qualify;
      wr(clm_pkg::OFS_CTRL, 32'h0000_0001, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_WINDOW, 32'h0000_0001, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_EXPECT, 32'h0000_0016, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_MARGIN, 32'h0002_0004, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_QUAL, 32'h0000_0022, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_CTRL, 32'h0000_0000, clm_pkg::RESP_OKAY);
      wait_out(1'b0, 1'b0);
      wait_out(1'b1, 1'b0);
      rd_chk(clm_pkg::OFS_STATE, 32'h0000_0000, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_EVENT, 32'h0000_0001, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_EVENT, 32'h0000_0000, clm_pkg::RESP_OKAY);
   endtask

   task automatic t_disqualify;
      mon_half <= 20;
      wait_out(1'b0, 1'b1);
      rd_chk(clm_pkg::OFS_TALLY, 32'h0000_0001, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_EVENT, 32'h0000_0003, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_EVENT, 32'h0000_0003, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_EVENT, 32'h0000_0003, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_TALLY, 32'h0000_0000, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_EVENT, 32'h0000_0003, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_EVENT, 32'h0000_0001, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_CTRL, 32'h0000_0500, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_TALLY, 32'h0000_0005, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_EVENT, 32'h0000_0003, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_EVENT, 32'h0000_0001, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_TALLY, 32'h0000_0006, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_EVENT, 32'h0000_0003, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_TALLY, 32'h0000_0006, clm_pkg::RESP_OKAY);
   endtask

   task automatic t_mask;
      wr(clm_pkg::OFS_CTRL, 32'h0000_0520, clm_pkg::RESP_OKAY);
      wait_out(1'b1, 1'b0);
      rd_chk(clm_pkg::OFS_STATE, 32'h0000_0001, clm_pkg::RESP_OKAY);
      freq_inv <= 1'b1;
      wait_out(1'b1, 1'b1);
      freq_inv <= 1'b0;
      wait_out(1'b1, 1'b0);
   endtask

   task automatic t_write_block;
      wr(clm_pkg::OFS_CTRL, 32'h0000_0501, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_TALLY, 32'h0000_0009, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_TALLY, 32'h0000_0006, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_CTRL, 32'h0000_0502, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_TALLY, 32'h0000_0009, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_TALLY, 32'h0000_0006, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_CTRL, 32'h0000_0000, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_TALLY, 32'h0000_000F, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_TALLY, 32'h0000_000F, clm_pkg::RESP_OKAY);
   endtask

   // Preset tally at its ceiling, then a fresh loss must not wrap it
   task automatic t_saturate;
      mon_half <= 10;
      wait_out(1'b0, 1'b0);
      wr(clm_pkg::OFS_EXPECT, 32'h0000_0000, clm_pkg::RESP_OKAY);
      wait_out(1'b0, 1'b1);
      rd_chk(clm_pkg::OFS_TALLY, 32'h0000_000F, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_STATE, 32'h0000_0000, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_STATE, 32'h0000_0003, clm_pkg::RESP_OKAY);
      wr(clm_pkg::OFS_CTRL, 32'h0000_0020, clm_pkg::RESP_OKAY);
      rd_chk(clm_pkg::OFS_STATE, 32'h0000_0001, clm_pkg::RESP_OKAY);
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      t_reset_values();
      t_qualify();
      t_disqualify();
      t_mask();
      t_write_block();
      t_saturate();
      report_and_stop();
   end

   // Whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      report_and_stop();
   end
endmodule

bind clm_top clm_top_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .freq_invalid_i(freq_invalid_i),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .los_status_o(los_status_o),
   .ref_invalid_o(ref_invalid_o));

/* File: clm_win_if.sv */
`timescale 1ns/1ps
interface clm_win_if;
   logic                        enable;
   logic [clm_pkg::DIV_W-1:0]   div_ratio;
   logic                        win_done;
   logic [clm_pkg::EXP_W-1:0]   win_count;

   modport meas (
      input  enable,
      input  div_ratio,
      output win_done,
      output win_count
   );

   modport ctrl (
      output enable,
      output div_ratio,
      input  win_done,
      input  win_count
   );
endinterface

/* File: clm_window_meas.sv */
`timescale 1ns/1ps
module clm_window_meas (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic mon_clk_i,
   clm_win_if.meas   win
);

   logic                        mon_prev;
   logic [clm_pkg::DIV_W-1:0]   edge_cnt;
   logic [clm_pkg::EXP_W-1:0]   period_cnt;
   logic [clm_pkg::DIV_W-1:0]   ratio_eff;
   logic                        mon_rise;
   logic                        last_edge;
   logic                        saturated;

   // zero or one divide by one
   assign ratio_eff = (win.div_ratio <= clm_pkg::DIV_ONE) ? clm_pkg::DIV_ONE : win.div_ratio;
   assign mon_rise  = mon_clk_i & ~mon_prev;
   assign last_edge = mon_rise && (edge_cnt >= ratio_eff - clm_pkg::DIV_ONE);
   // A dead clock never closes a window, so a full count closes it
   assign saturated = (period_cnt == clm_pkg::COUNT_MAX);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mon_prev <= 1'b0;
      end else begin
         mon_prev <= mon_clk_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         edge_cnt      <= '0;
         period_cnt    <= '0;
         win.win_done  <= 1'b0;
         win.win_count <= '0;
      end else if (!win.enable) begin
         edge_cnt     <= '0;
         period_cnt   <= '0;
         win.win_done <= 1'b0;
      end else begin
         win.win_done <= last_edge | saturated;
         if (last_edge || saturated) begin
            win.win_count <= period_cnt;
            // Closing cycle is already the first period of the next window
            period_cnt    <= 16'h0001;
            edge_cnt      <= '0;
         end else begin
            period_cnt <= period_cnt + 16'h0001;
            if (mon_rise) begin
               edge_cnt <= edge_cnt + clm_pkg::DIV_ONE;
            end
         end
      end
   end

endmodule
